// file: core/asr_host.sv
// Purpose: Host controller driving an asynchronous 16-bit static memory.
// Assumes: One request at a time; memory pins are reached through the
//   three-signal data bus and plain strobe outputs.
// Notes: Strobes and data all come from flip-flops, so no glitches reach
//   the memory. Read data is sampled at the end of the strobe window.
`default_nettype none
module asr_host (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          req_valid,
  output logic                               req_ready,
  input  wire asr_pkg::asr_req_t             req,
  output logic                               rsp_valid,
  output logic [asr_pkg::DATA_W-1:0]         rsp_rdata,
  output logic [asr_pkg::ADDR_W-1:0]         mem_addr,
  output asr_pkg::asr_strobe_t               mem_strobe,
  input  wire logic [asr_pkg::DATA_W-1:0]    mem_data_in,
  output logic [asr_pkg::DATA_W-1:0]         mem_data_out,
  output logic                               mem_data_oe_n
);
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_SETUP = 6'h02,
    ST_READ  = 6'h04,
    ST_WRITE = 6'h08,
    ST_HOLD  = 6'h10,
    ST_TURN  = 6'h20
  } asr_state_t;

  asr_state_t                      state_ff;
  asr_state_t                      nxt_state;
  logic                            write_ff;
  logic [1:0]                      lanes_ff;
  logic [asr_pkg::ADDR_W-1:0]      addr_ff;
  logic [asr_pkg::DATA_W-1:0]      wdata_ff;
  logic [asr_pkg::DATA_W-1:0]      rdata_ff;
  logic [asr_pkg::DATA_W-1:0]      rd_masked;
  logic                            rsp_ff;
  asr_pkg::asr_strobe_t            strobe_ff;
  logic                            oe_n_ff;
  logic [asr_pkg::DATA_W-1:0]      sync1_ff;
  logic [asr_pkg::DATA_W-1:0]      sync2_ff;
  logic                            tmr_load;
  logic [asr_pkg::CNT_W-1:0]       tmr_count;
  logic                            tmr_done;
  logic                            accept;

  assign req_ready = (state_ff == ST_IDLE);
  // A request with no lane selected would only deselect; it is dropped.
  assign accept    = req_valid && req_ready && (req.lanes != 2'h0);

  asr_timer u_timer (
    .clk   (clk),
    .rst   (rst),
    .load  (tmr_load),
    .count (tmr_count),
    .done  (tmr_done)
  );

  always_comb begin
    nxt_state = state_ff;
    tmr_load  = 1'b0;
    tmr_count = 4'h1;
    case (state_ff)
      ST_IDLE: begin
        if (accept) begin
          nxt_state = ST_SETUP;
          tmr_load  = 1'b1;
        end
      end
      ST_SETUP: begin
        if (tmr_done) begin
          tmr_load = 1'b1;
          if (write_ff) begin
            nxt_state = ST_WRITE;
            tmr_count = asr_pkg::CNT_W'(asr_pkg::WRITE_CYC);
          end else begin
            nxt_state = ST_READ;
            tmr_count = asr_pkg::CNT_W'(asr_pkg::READ_CYC + 1);
          end
        end
      end
      ST_READ: begin
        if (tmr_done) begin
          nxt_state = ST_TURN;
          tmr_load  = 1'b1;
          tmr_count = asr_pkg::CNT_W'(asr_pkg::TURN_CYC);
        end
      end
      ST_WRITE: begin
        if (tmr_done) begin
          nxt_state = ST_HOLD;
          tmr_load  = 1'b1;
        end
      end
      ST_HOLD: begin
        if (tmr_done) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_TURN: begin
        if (tmr_done) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Address and data are latched once and held for the whole access.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      write_ff <= 1'b0;
      lanes_ff <= 2'h0;
      addr_ff  <= 18'h00000;
      wdata_ff <= asr_pkg::DATA_RST;
    end else if (accept) begin
      write_ff <= req.write;
      lanes_ff <= req.lanes;
      addr_ff  <= req.addr;
      wdata_ff <= req.wdata;
    end
  end

  assign mem_addr     = addr_ff;
  assign mem_data_out = wdata_ff;

  // Strobes. Setup phase drives only the address, so it settles before
  // any select falls. Write ends on the write strobe; select and lanes
  // fall away one cycle later so data hold is met against that edge.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strobe_ff <= '{select_first_n: 1'b1, select_second_hi: 1'b0,
                     write_n: 1'b1, out_en_n: 1'b1,
                     upper_byte_sel_n: 1'b1, lower_byte_sel_n: 1'b1};
    end else begin
      strobe_ff.select_first_n   <= 1'b1;
      strobe_ff.select_second_hi <= 1'b0;
      strobe_ff.write_n          <= 1'b1;
      strobe_ff.out_en_n         <= 1'b1;
      strobe_ff.upper_byte_sel_n <= 1'b1;
      strobe_ff.lower_byte_sel_n <= 1'b1;
      if (nxt_state == ST_READ || nxt_state == ST_WRITE ||
          nxt_state == ST_HOLD) begin
        strobe_ff.select_first_n   <= 1'b0;
        strobe_ff.select_second_hi <= 1'b1;
        strobe_ff.upper_byte_sel_n <= ~lanes_ff[1];
        strobe_ff.lower_byte_sel_n <= ~lanes_ff[0];
      end
      if (nxt_state == ST_READ) begin
        strobe_ff.out_en_n <= 1'b0;
      end
      if (nxt_state == ST_WRITE) begin
        strobe_ff.write_n <= 1'b0;
      end
    end
  end

  assign mem_strobe = strobe_ff;

  // Data pins are driven only through a write and its hold cycle, never
  // while output drive is low, so the two ends cannot fight.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      oe_n_ff <= 1'b1;
    end else begin
      oe_n_ff <= ~(write_ff && (nxt_state == ST_WRITE ||
                               nxt_state == ST_HOLD));
    end
  end

  assign mem_data_oe_n = oe_n_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_ff <= asr_pkg::DATA_RST;
      sync2_ff <= asr_pkg::DATA_RST;
    end else begin
      sync1_ff <= mem_data_in;
      sync2_ff <= sync1_ff;
    end
  end

  for (genvar ln = 0; ln < 2; ln++) begin : g_lane
    assign rd_masked[ln*asr_pkg::LANE_W +: asr_pkg::LANE_W] =
      lanes_ff[ln] ? sync2_ff[ln*asr_pkg::LANE_W +: asr_pkg::LANE_W]
                   : 8'h00;
  end

  // Read data is taken from the second stage when the read window ends;
  // the one extra strobe cycle covers one of the two synchroniser stages. Unselected
  // lanes return zero because the memory floats them.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= asr_pkg::DATA_RST;
      rsp_ff   <= 1'b0;
    end else begin
      rsp_ff <= 1'b0;
      if (state_ff == ST_READ && tmr_done) begin
        rdata_ff <= rd_masked;
        rsp_ff   <= 1'b1;
      end else if (state_ff == ST_HOLD && tmr_done) begin
        rsp_ff <= 1'b1;
      end
    end
  end

  assign rsp_valid = rsp_ff;
  assign rsp_rdata = rdata_ff;
endmodule
`default_nettype wire

// file: core/asr_pkg.sv
// Purpose: Shared constants and carriers for the static memory host port.
// Assumes: 50 MHz system clock, 16-bit word, 18-bit word address.
// Notes: Timing counts are derived from nanosecond figures.
`default_nettype none
package asr_pkg;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned ADDR_W        = 18;
  localparam int unsigned DATA_W        = 16;
  localparam int unsigned LANE_W        = 8;
  localparam int unsigned LANE_LO_LSB   = 0;
  localparam int unsigned LANE_HI_LSB   = 8;
  // Minimum times in ns, rounded up to whole clock cycles below.
  localparam int unsigned READ_CYCLE_NS   = 55;
  localparam int unsigned WRITE_PULSE_NS  = 40;
  localparam int unsigned DATA_SETUP_NS   = 25;
  localparam int unsigned TURNAROUND_NS   = 20;
  localparam int unsigned READ_CYC =
    (READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WRITE_CYC =
    (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETUP_CYC =
    (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TURN_CYC =
    (TURNAROUND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 4;
  localparam logic [15:0] DATA_RST = 16'h0000;

  typedef struct packed {
    logic                  write;
    logic [1:0]            lanes;   // Bit 1 upper lane, bit 0 lower lane.
    logic [ADDR_W-1:0]     addr;
    logic [DATA_W-1:0]     wdata;
  } asr_req_t;

  typedef struct packed {
    logic                  select_first_n;
    logic                  select_second_hi;
    logic                  write_n;
    logic                  out_en_n;
    logic                  upper_byte_sel_n;
    logic                  lower_byte_sel_n;
  } asr_strobe_t;
endpackage
`default_nettype wire

// file: core/asr_timer.sv
// Purpose: Down counter that times one phase of a memory access.
// Assumes: Loaded with a count of at least one.
// Notes: done is high in the cycle the count reaches one.
`default_nettype none
module asr_timer (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      load,
  input  wire logic [asr_pkg::CNT_W-1:0] count,
  output logic                           done
);
  logic [asr_pkg::CNT_W-1:0] cnt_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 4'h0;
    end else if (load) begin
      cnt_ff <= count;
    end else if (cnt_ff != 4'h0) begin
      cnt_ff <= cnt_ff - 4'h1;
    end
  end

  assign done = (cnt_ff == 4'h1);
endmodule
`default_nettype wire

// file: bench/asr_mem_model.sv
// Purpose: Behavioural model of the asynchronous 16-bit static memory.
// Assumes: Strobes come from host flip-flops, so they carry no glitches.
// Notes: A lane that is not driven shows the inverse of the stored lane.
`default_nettype none
module asr_mem_model (
  input  wire logic [17:0]          addr,
  input  wire asr_pkg::asr_strobe_t stb,
  input  wire logic [15:0]          din,
  output logic [15:0]               dout
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:262143];
  logic [15:0] w;
  logic        sel;
  logic        act;
  logic [1:0]  ln;
  initial foreach (mem[i]) mem[i] = 16'h0000;
  assign sel = !stb.select_first_n && stb.select_second_hi;
  assign ln  = ~{stb.upper_byte_sel_n, stb.lower_byte_sel_n};
  assign act = sel && (ln != 2'h0);
  always @(addr or stb or din) begin
    w = mem[addr];
    if (act && !stb.write_n) begin
      if (ln[0]) w[7:0] = din[7:0];
      if (ln[1]) w[15:8] = din[15:8];
      mem[addr] = w;
    end
    dout = ~w;
    if (act && stb.write_n && !stb.out_en_n) begin
      if (ln[0]) dout[7:0] = w[7:0];
      if (ln[1]) dout[15:8] = w[15:8];
    end
  end
endmodule
`default_nettype wire

// file: bench/asr_host_assertions.sv
// Purpose: Port-level timing checks of the static memory host.
// Assumes: Cycle counts of the hand-over timing walk.
// Notes: Bound to every host instance.
`default_nettype none
module asr_host_assertions (
  input wire logic                       clk,
  input wire logic                       rst,
  input wire logic                       req_valid,
  input wire logic                       req_ready,
  input wire asr_pkg::asr_req_t          req,
  input wire logic                       rsp_valid,
  input wire logic [asr_pkg::ADDR_W-1:0] mem_addr,
  input wire asr_pkg::asr_strobe_t       mem_strobe,
  input wire logic [asr_pkg::DATA_W-1:0] mem_data_out,
  input wire logic                       mem_data_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic acc;
  logic fs;
  assign acc = req_valid && req_ready && (req.lanes != 2'h0);
  assign fs  = mem_strobe.select_first_n;
  sel_pair_a: assert property (
    !fs |-> mem_strobe.select_second_hi) else $error("second select low");
  rd_we_high_a: assert property (
    !mem_strobe.out_en_n |-> mem_strobe.write_n) else $error("read write");
  no_clash_a: assert property (
    !mem_strobe.out_en_n |-> mem_data_oe_n) else $error("bus clash");
  addr_hold_a: assert property (
    !fs |-> $stable(mem_addr)) else $error("address moved");
  rd_walk_a: assert property (
    acc && !req.write |-> ##1 fs ##1 (!fs && !mem_strobe.out_en_n)[*4]
    ##1 (fs && rsp_valid)) else $error("read walk");
  wr_walk_a: assert property (
    acc && req.write |-> ##2
    (!fs && !mem_strobe.write_n && !mem_data_oe_n)[*2]
    ##1 (!fs && mem_strobe.write_n)
    ##1 (fs && rsp_valid && mem_data_oe_n)) else $error("write walk");
  wd_hold_a: assert property (
    $rose(mem_strobe.write_n) |-> $stable(mem_data_out) && !mem_data_oe_n)
    else $error("write data hold");
  lane_map_a: assert property (
    acc |-> ##2 ({mem_strobe.upper_byte_sel_n, mem_strobe.lower_byte_sel_n}
    == ~$past(req.lanes, 2) && mem_addr == $past(req.addr, 2)))
    else $error("lane or address");
  empty_drop_a: assert property (
    req_valid && req_ready && req.lanes == 2'h0 |-> ##1 (fs && !rsp_valid)[*6])
    else $error("empty request ran");
  wr_data_a: assert property (
    acc && req.write |-> ##2 mem_data_out == $past(req.wdata, 2))
    else $error("write data");
endmodule
bind asr_host asr_host_assertions u_chk (.clk(clk), .rst(rst),
  .req_valid(req_valid), .req_ready(req_ready), .req(req),
  .rsp_valid(rsp_valid), .mem_addr(mem_addr), .mem_strobe(mem_strobe),
  .mem_data_out(mem_data_out), .mem_data_oe_n(mem_data_oe_n));
`default_nettype wire

// file: bench/testbench.sv
// Purpose: Self-checking bench for the static memory host port.
// Assumes: One request at a time, taken while req_ready is high.
// Notes: Expected words are built from the lane rules alone.
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin miscompares++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 clk = 1'b0;
  logic                 rst = 1'b1;
  logic                 req_valid = 1'b0;
  asr_pkg::asr_req_t    req = '0;
  logic                 req_ready;
  logic                 rsp_valid;
  logic                 oe_n;
  logic                 g;
  logic [15:0]          rdata;
  logic [15:0]          dout;
  logic [15:0]          pin;
  logic [15:0]          wdat;
  logic [15:0]          q;
  logic [17:0]          addr;
  asr_pkg::asr_strobe_t stb;
  int                   miscompares = 0;
  int                   compares = 0;
  int                   cyc = 0;
  always #10 clk = ~clk;
  assign pin = oe_n ? dout : wdat;
  asr_host u_dut (.clk(clk), .rst(rst), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
    .rsp_rdata(rdata), .mem_addr(addr), .mem_strobe(stb),
    .mem_data_in(pin), .mem_data_out(wdat), .mem_data_oe_n(oe_n));
  // The model sees host data only; a write with pins floated would loop.
  asr_mem_model u_mem (.addr(addr), .stb(stb), .din(wdat), .dout(dout));
  task automatic xfer(input logic w, input logic [1:0] ln,
      input logic [17:0] a, input logic [15:0] d);
    g = 1'b0;
    q = 16'h0000;
    while (req_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{write: w, lanes: ln, addr: a, wdata: d};
    @(posedge clk);
    req_valid <= 1'b0;
    for (int n = 0; n < 12 && !g; n++) begin
      @(negedge clk);
      g = (rsp_valid === 1'b1);
    end
    if (g) q = rdata;
  endtask
  task automatic t_full;
    xfer(1'b1, 2'h3, 18'h3ffff, 16'ha5c3);
    `CHK(g, 1'b1)
    xfer(1'b0, 2'h3, 18'h3ffff, 16'h0000);
    `CHK(q, 16'ha5c3)
  endtask
  task automatic t_lanes;
    xfer(1'b1, 2'h3, 18'h00012, 16'h1234);
    xfer(1'b1, 2'h1, 18'h00012, 16'hffab);
    xfer(1'b1, 2'h2, 18'h00012, 16'hcdff);
    xfer(1'b0, 2'h3, 18'h00012, 16'h0000);
    `CHK(q, 16'hcdab)
    xfer(1'b0, 2'h1, 18'h00012, 16'h0000);
    `CHK(q, 16'h00ab)
    xfer(1'b0, 2'h2, 18'h00012, 16'h0000);
    `CHK(q, 16'hcd00)
  endtask
  task automatic t_drop;
    xfer(1'b1, 2'h0, 18'h00012, 16'h0000);
    `CHK(g, 1'b0)
    xfer(1'b0, 2'h3, 18'h00012, 16'h0000);
    `CHK(q, 16'hcdab)
  endtask
  task automatic t_addr;
    xfer(1'b1, 2'h3, 18'h00000, 16'h0f0f);
    xfer(1'b1, 2'h3, 18'h20000, 16'hf0f0);
    xfer(1'b0, 2'h3, 18'h00000, 16'h0000);
    `CHK(q, 16'h0f0f)
    xfer(1'b0, 2'h3, 18'h20000, 16'h0000);
    `CHK(q, 16'hf0f0)
  endtask
  task automatic end_of_test;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      end_of_test();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_full();
    t_lanes();
    t_drop();
    t_addr();
    end_of_test();
  end
endmodule
`default_nettype wire
